/* dv/fan_monitor_control_regs_tb_top.sv */
// Testbench: fan control register bank against a behavioural model
`timescale 1ns/1ns
module fan_monitor_control_regs_tb_top;
  import fan_ctrl_pkg::*;
  localparam logic [3:0] DEV = 4'h3; // Arbitrary value
  localparam logic [2:0] REV = 3'h5; // Arbitrary value
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic convertersOk = 1'b0;
  logic algoUpdate = 1'b0;
  logic [PWM_CHANNELS-1:0][7:0] algoDuty = '0;
  logic [PWM_CHANNELS-1:0] pwmDisabled = '0;
  logic [PWM_CHANNELS-1:0][7:0] pwmDuty;
  logic useProgrammed, paramWrite, paramLocked;
  logic [7:0] regRdata, rd, v;
  reg_req_t regReq;
  int n_errors = 0, num_checks = 0, cycles = 0, pwCount = 0, pwExp = 0;
  int mStart = 0, mLock = 0, mForce = 0, mReady = 0;
  int mDuty[3] = '{255, 255, 255};
  always #10 clk_sys = ~clk_sys;
  fan_monitor_control_regs #(.DEVICE_NUMBER(DEV), .SILICON_REV(REV)) dut_u (
    .clk_sys(clk_sys), .rstn(rstn), .regReq(regReq), .regRdata(regRdata),
    .convertersOk(convertersOk), .algoDuty(algoDuty),
    .algoUpdate(algoUpdate), .pwmDisabled(pwmDisabled),
    .useProgrammed(useProgrammed), .paramWrite(paramWrite),
    .paramLocked(paramLocked), .pwmDuty(pwmDuty));
  reg_host_model host_u (.clk_sys(clk_sys), .regRdata(regRdata),
    .regReq(regReq));
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (paramWrite === 1'b1) pwCount <= pwCount + 1;
    if (cycles == 3000)
    begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wctl(logic [7:0] d);
    host_u.bus_write(OFS_CONTROL, d);
    mStart = d[0];
    if (mLock == 0) mLock = d[1];
    mForce = d[3];
    host_u.bus_read(OFS_CONTROL, rd);
    v = {4'h0, mForce[0], mReady[0], mLock[0], mStart[0]};
    check("control", rd, v);
    check("useProgrammed", {7'h0, useProgrammed}, mStart[7:0]);
    check("paramLocked", {7'h0, paramLocked}, mLock[7:0]);
  endtask
  task automatic wparam();
    host_u.bus_write(OFS_PARAM_FIRST + 8'($urandom % 19), 8'($urandom));
    if (mLock == 0) pwExp++;
    check("paramWrite count", pwCount[7:0], pwExp[7:0]);
  endtask
  task automatic upd();
    algoDuty = 24'($urandom);
    pwmDisabled = 3'($urandom);
    algoUpdate = 1'b1;
    @(negedge clk_sys);
    algoUpdate = 1'b0;
    for (int i = 0; i < 3; i++)
      if (mStart != 0) mDuty[i] = algoDuty[i];
  endtask
  task automatic check_duty();
    for (int i = 0; i < 3; i++)
    begin
      host_u.bus_read(OFS_DUTY_FIRST + 8'(i), rd);
      check("duty reg", rd, mDuty[i][7:0]);
      v = mForce ? DUTY_FULL : pwmDisabled[i] ? DUTY_OFF : mDuty[i][7:0];
      check("pwmDuty", pwmDuty[i], v);
    end
  endtask
  task automatic wrap_up();
    if (n_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    void'($urandom(32'h54a8));
    repeat (2) @(negedge clk_sys);
    rstn = 1'b1;
    host_u.bus_read(OFS_VERSION, rd);
    check("version", rd, {DEV, 1'b1, REV});
    host_u.bus_write(OFS_VERSION, 8'($urandom));
    host_u.bus_read(OFS_VERSION, rd);
    check("version kept", rd, {DEV, 1'b1, REV});
    wctl(8'h00);
    convertersOk = 1'b1;
    mReady = 1;
    @(negedge clk_sys);
    // Reserved bits written high must read back low
    wctl(8'hF0);
    check_duty();
    upd();
    check_duty();
    // Limits programmed before start
    repeat (2) wparam();
    wctl(8'h01);
    upd();
    check_duty();
    wctl(8'h09);
    check_duty();
    wctl(8'h03);
    repeat (2) wparam();
    wctl(8'h08);
    upd();
    check_duty();
    wctl(8'h01);
    upd();
    check_duty();
    wrap_up();
  end
endmodule

/* dv/reg_host_model.sv */
// Register master model: byte strobe requests from the serial engine side
`timescale 1ns/1ns
module reg_host_model
(
  // Clock
  input  wire logic              clk_sys,
  // Register port
  input  wire logic [7:0]        regRdata,
  output fan_ctrl_pkg::reg_req_t regReq
);
  import fan_ctrl_pkg::*;
  initial regReq = '0;
  // Idle lines show the inverse, so a stale value is never mistaken for data
  // Each request waits for its own falling edge, so back to back calls
  // leave one idle cycle and never drive the strobe twice in one step
  task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    regReq = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clk_sys);
    regReq = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask
  task automatic bus_read(input logic [7:0] a, output logic [7:0] q);
    @(negedge clk_sys);
    regReq = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge clk_sys);
    q = regRdata;
    regReq = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'hFF};
  endtask
endmodule

/* hdl/fan_ctrl_pkg.sv */
// Package: register map, field layout and types of the fan control bank
// -----------------------------------------------------------------------
// -----------------------------------------------------------------------
package fan_ctrl_pkg;

  // -------------------------------------------------------------------
  // Register offsets
  // -------------------------------------------------------------------
  localparam logic [7:0] OFS_DUTY_FIRST  = 8'h30;
  localparam logic [7:0] OFS_VERSION     = 8'h3F;
  localparam logic [7:0] OFS_CONTROL     = 8'h40;
  localparam logic [7:0] OFS_PARAM_FIRST = 8'h5C;
  localparam logic [7:0] OFS_PARAM_LAST  = 8'h6E;

  // -------------------------------------------------------------------
  // Field layout and values
  // -------------------------------------------------------------------
  localparam int          CTL_START_BIT = 0;
  localparam int          CTL_LOCK_BIT  = 1;
  localparam int          CTL_READY_BIT = 2;
  localparam int          CTL_FORCE_BIT = 3;
  localparam logic [7:0]  CTL_RESERVED  = 8'h00;
  localparam logic [3:0]  REV_SUPERSET  = 4'h8;
  localparam logic [7:0]  DUTY_FULL     = 8'hFF;
  localparam logic [7:0]  DUTY_OFF      = 8'h00;
  localparam logic [7:0]  READ_NONE     = 8'h00;
  localparam int          PWM_CHANNELS  = 3;

  // -------------------------------------------------------------------
  // Types
  // -------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic                          start;
    logic                          lock;
    logic                          ready;
    logic                          pwmFullDutyForce;
    logic [PWM_CHANNELS-1:0][7:0]  duty;
    logic [7:0]                    rdata;
  } ctl_state_t;

endpackage

/* hdl/fan_monitor_control_regs.sv */
// Identity and global fan control registers with duty and limit gating
`timescale 1ns/1ns
module fan_monitor_control_regs
#(
  parameter logic [3:0] DEVICE_NUMBER = 4'h3, // Arbitrary value
  parameter logic [2:0] SILICON_REV   = 3'h1  // Arbitrary value
)
(
  // Clock and reset
  input  wire logic                              clk_sys,
  input  wire logic                              rstn,
  // Register access from the serial bus engine
  input  wire fan_ctrl_pkg::reg_req_t            regReq,
  output logic [7:0]                             regRdata,
  // Converter health
  input  wire logic                              convertersOk,
  // Fan algorithm side
  input  wire logic [fan_ctrl_pkg::PWM_CHANNELS-1:0][7:0] algoDuty,
  input  wire logic                              algoUpdate,
  input  wire logic [fan_ctrl_pkg::PWM_CHANNELS-1:0] pwmDisabled,
  // Parameter set control
  output logic                                   useProgrammed,
  output logic                                   paramWrite,
  output logic                                   paramLocked,
  // PWM duty per output
  output logic [fan_ctrl_pkg::PWM_CHANNELS-1:0][7:0] pwmDuty
);
  import fan_ctrl_pkg::*;

  // ---------------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------------
  function automatic logic inParamRange(input logic [7:0] a);
    inParamRange = (a >= OFS_PARAM_FIRST) && (a <= OFS_PARAM_LAST);
  endfunction

  function automatic logic [7:0] ctlByte(input ctl_state_t s);
    logic [7:0] b;
    b = CTL_RESERVED;
    b[CTL_START_BIT] = s.start;
    b[CTL_LOCK_BIT]  = s.lock;
    b[CTL_READY_BIT] = s.ready;
    b[CTL_FORCE_BIT] = s.pwmFullDutyForce;
    ctlByte = b;
  endfunction

  ctl_state_t state;
  ctl_state_t next_state;
  logic [7:0] versionByte;
  logic       ctlWrite;

  assign versionByte = {DEVICE_NUMBER, REV_SUPERSET | {1'b0, SILICON_REV}};
  assign ctlWrite    = regReq.wr && (regReq.addr == OFS_CONTROL);

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    // Start is written regardless of lock
    if (ctlWrite)
    begin
      next_state.start = regReq.wdata[CTL_START_BIT];
      next_state.pwmFullDutyForce = regReq.wdata[CTL_FORCE_BIT];
      if (!state.lock)
      begin
        next_state.lock = regReq.wdata[CTL_LOCK_BIT];
      end
    end
    // Ready only ever rises; a later converter fault does not drop it
    if (convertersOk)
    begin
      next_state.ready = 1'b1;
    end
    // Duty follows the algorithm only once started
    if (state.start && algoUpdate)
    begin
      next_state.duty = algoDuty;
    end
    // Read data, unmapped offsets answer zero; version has no write path
    next_state.rdata = READ_NONE;
    if (regReq.rd)
    begin
      if (regReq.addr == OFS_VERSION)
      begin
        next_state.rdata = versionByte;
      end
      else if (regReq.addr == OFS_CONTROL)
      begin
        next_state.rdata = ctlByte(state);
      end
      else
      begin
        for (int i = 0; i < PWM_CHANNELS; i++)
        begin
          if (regReq.addr == OFS_DUTY_FIRST + 8'(i))
          begin
            next_state.rdata = state.duty[i];
          end
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state.start            <= 1'b0;
      state.lock             <= 1'b0;
      state.ready            <= 1'b0;
      state.pwmFullDutyForce <= 1'b0;
      state.duty             <= {PWM_CHANNELS{DUTY_FULL}};
      state.rdata            <= READ_NONE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  // Limit storage lives outside; only the write strobe is gated here, so
  // toggling start can never disturb the stored values.
  assign useProgrammed = state.start;
  assign paramLocked   = state.lock;
  assign paramWrite    = regReq.wr && inParamRange(regReq.addr)
                         && !state.lock;
  assign regRdata      = state.rdata;

  always_comb
  begin
    for (int i = 0; i < PWM_CHANNELS; i++)
    begin
      if (state.pwmFullDutyForce)
      begin
        pwmDuty[i] = DUTY_FULL;
      end
      else if (pwmDisabled[i])
      begin
        pwmDuty[i] = DUTY_OFF;
      end
      else
      begin
        pwmDuty[i] = state.duty[i];
      end
    end
  end

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  chk_version_read: assert property (
    regReq.rd && regReq.addr == OFS_VERSION |=>
      regRdata[7:4] == DEVICE_NUMBER && regRdata[2:0] == SILICON_REV)
    else $error("Version byte wrong");

  chk_superset_bit: assert property (
    $past(regReq.rd) && $past(regReq.addr) == OFS_VERSION |-> regRdata[3])
    else $error("Superset bit not set");

  chk_version_fixed: assert property (
    regReq.wr && regReq.addr == OFS_VERSION ##2
      regReq.rd && regReq.addr == OFS_VERSION |=>
      regRdata[7:4] == DEVICE_NUMBER && regRdata[3]
      && regRdata[2:0] == SILICON_REV)
    else $error("Version changed by write");

  chk_start_write: assert property (
    ctlWrite |=> useProgrammed == $past(regReq.wdata[CTL_START_BIT]))
    else $error("Start bit not taken");

  chk_start_locked: assert property (
    ctlWrite && paramLocked |=>
      useProgrammed == $past(regReq.wdata[CTL_START_BIT]))
    else $error("Start bit blocked by lock");

  chk_lock_gates: assert property (
    paramLocked |-> !paramWrite)
    else $error("Parameter write while locked");

  chk_lock_sticky: assert property (
    paramLocked |=> paramLocked)
    else $error("Lock cleared");

  chk_ready_rise: assert property (
    convertersOk |=> state.ready [*2])
    else $error("Ready not held");

  chk_force_full: assert property (
    ctlWrite && regReq.wdata[CTL_FORCE_BIT] |=>
      pwmDuty == {PWM_CHANNELS{DUTY_FULL}})
    else $error("Override not at full duty");

  chk_duty_hold: assert property (
    !useProgrammed |=> $stable(state.duty))
    else $error("Duty moved before start");

  chk_reserved_zero: assert property (
    $past(regReq.rd) && $past(regReq.addr) == OFS_CONTROL |->
      regRdata[7:4] == 4'h0)
    else $error("Reserved control bits not zero");

  chk_read_quiet: assert property (
    !regReq.rd |=> regRdata == READ_NONE)
    else $error("Read data left standing");

  chk_ctl_read: assert property (
    regReq.rd && regReq.addr == OFS_CONTROL |=>
      regRdata[CTL_START_BIT] == $past(useProgrammed)
      && regRdata[CTL_LOCK_BIT] == $past(paramLocked)
      && regRdata[CTL_READY_BIT] == $past(state.ready)
      && regRdata[CTL_FORCE_BIT] == $past(state.pwmFullDutyForce))
    else $error("Control byte does not match state");

  // ---------------------------------------------------------------------
  // Start and limit storage checks
  // ---------------------------------------------------------------------
  // Start may only move on a control write, so a stray strobe elsewhere
  // can never swap the active limit set under a running fan
  chk_start_only: assert property (
    !ctlWrite |=> $stable(useProgrammed))
    else $error("Start moved without a write");

  chk_start_clear: assert property (
    ctlWrite && !regReq.wdata[CTL_START_BIT] |=> !useProgrammed)
    else $error("Start not cleared");

  chk_start_no_param: assert property (
    ctlWrite |-> !paramWrite)
    else $error("Control write reached limit storage");

  chk_param_open: assert property (
    regReq.wr && regReq.addr >= OFS_PARAM_FIRST
      && regReq.addr <= OFS_PARAM_LAST && !paramLocked |-> paramWrite)
    else $error("Parameter write dropped while open");

  chk_param_range: assert property (
    paramWrite |-> regReq.wr && regReq.addr >= OFS_PARAM_FIRST
      && regReq.addr <= OFS_PARAM_LAST)
    else $error("Parameter write outside range");

  // ---------------------------------------------------------------------
  // Lock checks
  // ---------------------------------------------------------------------
  chk_lock_set: assert property (
    ctlWrite && regReq.wdata[CTL_LOCK_BIT] |=> paramLocked)
    else $error("Lock not taken");

  // Lock only comes from a write; only reset takes it away again
  chk_lock_cause: assert property (
    !paramLocked && !ctlWrite |=> !paramLocked)
    else $error("Lock set without a write");

  // ---------------------------------------------------------------------
  // Ready checks
  // ---------------------------------------------------------------------
  chk_ready_sticky: assert property (
    state.ready |=> state.ready)
    else $error("Ready dropped");

  chk_ready_cause: assert property (
    !state.ready && !convertersOk |=> !state.ready)
    else $error("Ready set without converters");

  // ---------------------------------------------------------------------
  // Override and duty checks
  // ---------------------------------------------------------------------
  chk_force_level: assert property (
    state.pwmFullDutyForce |->
      pwmDuty == {PWM_CHANNELS{DUTY_FULL}})
    else $error("Override held but duty not full");

  chk_force_clear: assert property (
    ctlWrite && !regReq.wdata[CTL_FORCE_BIT] |=> !state.pwmFullDutyForce)
    else $error("Override not cleared");

  chk_force_only: assert property (
    !ctlWrite |=> $stable(state.pwmFullDutyForce))
    else $error("Override moved without a write");

  chk_duty_load: assert property (
    useProgrammed && algoUpdate |=> state.duty == $past(algoDuty))
    else $error("Duty not loaded after start");

  chk_duty_steady: assert property (
    !algoUpdate |=> $stable(state.duty))
    else $error("Duty moved without an update");

  // Per output checks; the loop keeps them in step with PWM_CHANNELS
  for (genvar ch = 0; ch < PWM_CHANNELS; ch++)
  begin : chanChecks
    chk_duty_read: assert property (
      regReq.rd && regReq.addr == OFS_DUTY_FIRST + 8'(ch) |=>
        regRdata == $past(state.duty[ch]))
      else $error("Duty register read wrong");

    chk_disabled_off: assert property (
      !state.pwmFullDutyForce && pwmDisabled[ch] |->
        pwmDuty[ch] == DUTY_OFF)
      else $error("Disabled output not off");

    chk_duty_pass: assert property (
      !state.pwmFullDutyForce && !pwmDisabled[ch] |->
        pwmDuty[ch] == state.duty[ch])
      else $error("Output duty not from register");
  end

endmodule
